//--- verif/sbd_dma_tb.sv
// testbench: register access and tx/rx descriptor ring walks of the descriptor engine
`default_nettype none
module sbd_dma_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, mem_addr, q;
	logic pready, pslverr, mem_req, mem_we, mem_ack, tx_start, rx_grant, desc_irq, e;
	logic tx_done = 1'b0, rx_pending = 1'b0, rx_done = 1'b0;
	logic [15:0] mem_wdata, mem_rdata;
	logic [3:0] delay = 4'h0;
	sbd_pkg::sbd_tx_req_t tx_req;
	sbd_pkg::sbd_tx_res_t tx_res = '0;
	sbd_pkg::sbd_rx_buf_t rx_buf;
	sbd_pkg::sbd_rx_res_t rx_res = '0;
	int mismatches = 0, num_checks = 0, irq_cnt = 0;
	sbd_dma sbd_dma_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .tx_start(tx_start), .tx_req(tx_req), .tx_done(tx_done), .tx_res(tx_res),
		.rx_pending(rx_pending), .rx_grant(rx_grant), .rx_buf(rx_buf), .rx_done(rx_done), .rx_res(rx_res),
		.desc_irq(desc_irq));
	sbd_mem_model sbd_mem_model_i (.pclk(pclk), .presetn(presetn), .delay(delay), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ======================================================================
	// clock, interrupt pulse counter, watchdog
	always #10 pclk = ~pclk;
	always @(posedge pclk)
		if (desc_irq === 1'b1)
			irq_cnt++;
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches++; // a hang counts as a mismatch
		test_done();
	end
	// ======================================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] m(input int i);
		return {16'h0000, sbd_mem_model_i.mem[i]};
	endfunction
	// apb transfer: request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// software fills a descriptor: status, count in bits 15:4, pointer high then low
	task automatic put(input int h, input logic [15:0] st, input logic [11:0] len, input logic [31:0] p);
		sbd_mem_model_i.mem[h] = st;
		sbd_mem_model_i.mem[h + 1] = {len, 4'h0};
		sbd_mem_model_i.mem[h + 2] = p[31:16];
		sbd_mem_model_i.mem[h + 3] = p[15:0];
	endtask
	task automatic wait_clear(input int h);
		for (int n = 0; n < 300 && sbd_mem_model_i.mem[h][0] !== 1'b0; n++) @(posedge pclk);
		repeat (3) @(posedge pclk); // irq lands one cycle after the status write
	endtask
	task automatic tx_finish(input sbd_pkg::sbd_tx_res_t r);
		tx_done <= 1'b1;
		tx_res <= r;
		@(posedge pclk);
		tx_done <= 1'b0;
	endtask
	// ======================================================================
	// scenarios
	task automatic test_regs;
		apb(1'b0, sbd_pkg::A_CTRL, 32'h0);
		check(q, 32'h0);
		apb(1'b0, sbd_pkg::A_RXLEN, 32'h0);
		check(q, 32'h200);
		check({31'h0, pready}, 32'h1);
		apb(1'b1, sbd_pkg::A_RXBASE, 32'hFFFFFFFF);
		apb(1'b0, sbd_pkg::A_RXBASE, 32'h0);
		check(q, 32'hFFFFFFF8); // ring base kept aligned to the 8-byte entry
		apb(1'b1, sbd_pkg::A_STAT, 32'hFFFFFFFF); // read-only, write dropped
		apb(1'b0, sbd_pkg::A_STAT, 32'h0);
		check(q, 32'h0);
		apb(1'b0, 8'hFC, 32'h0); // unmapped place
		check({q[30:0], e}, 32'h1);
	endtask
	task automatic test_tx;
		delay <= 4'h3;
		put(32, 16'h0229, 12'h123, 32'h12345678); // ready, last, irq, unnumbered
		put(36, 16'h0043, 12'hFFF, 32'hCAFE0010); // ready, wrap, repeat, no irq
		apb(1'b1, sbd_pkg::A_TXBASE, 32'h40);
		apb(1'b1, sbd_pkg::A_CTRL, 32'h1);
		do @(posedge pclk); while (tx_start !== 1'b1);
		check(tx_req.addr, 32'h12345678);
		check({17'h0, tx_req.len, tx_req.last, tx_req.unnumbered, tx_req.repeat_packet_flag}, 32'h0000091E);
		tx_finish(3'b100);
		wait_clear(32);
		check(m(32), 32'h02A8);
		check(irq_cnt, 32'h1);
		do @(posedge pclk); while (tx_start !== 1'b1);
		check(tx_req.addr, 32'hCAFE0010);
		check({17'h0, tx_req.len, tx_req.last, tx_req.unnumbered, tx_req.repeat_packet_flag}, 32'h00007FF9);
		tx_finish(3'b011);
		wait_clear(36);
		check(m(36), 32'h0542);
		check(irq_cnt, 32'h1);
		apb(1'b0, sbd_pkg::A_STAT, 32'h0);
		check(q[7:0], 8'h00);
	endtask
	task automatic test_rx;
		delay <= 4'h0;
		apb(1'b1, sbd_pkg::A_RXBASE, 32'h80);
		apb(1'b1, sbd_pkg::A_CTRL, 32'h3);
		for (int i = 0; i < 2; i++)
		begin
			put(64, 16'h0023, 12'h000, 32'h0BADF00D); // empty, wrap, irq
			rx_pending <= 1'b1;
			do @(posedge pclk); while (rx_grant !== 1'b1);
			check(rx_buf.addr, 32'h0BADF00D);
			check({20'h0, rx_buf.cap}, 32'h200);
			rx_done <= 1'b1;
			rx_pending <= 1'b0;
			rx_res <= (i == 0) ? {12'h05A, 10'h3FF} : {12'h7FF, 10'h000};
			@(posedge pclk);
			rx_done <= 1'b0;
			wait_clear(64);
			check(m(65) >> 4, (i == 0) ? 32'h05A : 32'h7FF);
			check(m(64), (i == 0) ? {16'h0, 16'h0022 | sbd_pkg::RX_RES_MASK} : 32'h0022);
			check(irq_cnt, 2 + i);
		end
	endtask
	task automatic test_cont;
		delay <= 4'h1;
		put(32, 16'h0024, 12'h010, 32'h00ABCDEF); // continuous, irq, ready clear
		do @(posedge pclk); while (tx_start !== 1'b1);
		check(tx_req.addr, 32'h00ABCDEF);
		tx_finish(3'b001);
		do @(posedge pclk); while (desc_irq !== 1'b1);
		check(m(32), 32'h0424);
		apb(1'b0, sbd_pkg::A_STAT, 32'h0);
		check(q[7:0], 8'h00);
		do @(posedge pclk); while (tx_start !== 1'b1);
		check(tx_req.addr, 32'h00ABCDEF);
	endtask
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ======================================================================
	// main sequence
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_tx();
		test_rx();
		test_cont();
		test_done();
	end
endmodule
`default_nettype wire

//--- verif/sbd_mem_model.sv
// partner model: halfword memory holding the descriptor rings, answering after a set delay
`default_nettype none
module sbd_mem_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] delay,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// descriptors are filled by the bench before ownership is handed over
	logic [15:0] mem [0:255];
	logic [3:0] wait_r;
	// ======================================================================
	// one access per request; the data line toggles outside an ack so stale data never looks valid
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ack <= 1'b0;
			wait_r <= 4'h0;
			mem_rdata <= 16'h0000;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack)
			begin
				if (wait_r >= delay)
				begin
					mem_ack <= 1'b1;
					wait_r <= 4'h0;
					mem_rdata <= mem[mem_addr[8:1]]; // halfwords at +0 +2 +4 +6
					if (mem_we)
						mem[mem_addr[8:1]] <= mem_wdata;
				end
				else
					wait_r <= wait_r + 4'h1; // slow answer stretches the access
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/sbd_dma.sv
// descriptor ring engine: walks tx and rx descriptor tables in external memory
// Function
// - descriptors and buffers fetched from external memory rings
// - one tx, one rx table, 256 entries
// - halfword +0 holds status and control
// - halfword +2 bits 4-15 hold count
// - buffer address from +4 high, +6 low
// - tx bit0 set means buffer ready
// - rx bit0 set means buffer empty
// - bit1 wraps back to first descriptor
// - bit2 continuous mode ignores ready bit
// - bit3 marks frame end, tx and rx
// - rx bit4 set on frame start buffer
// - bit5 raises interrupt after descriptor done
// - tx bit6 allows repeated packet sending
// - tx bit7 set on abort
// - tx bit8 set on fifo underrun
// - tx bit9 sends frame as unnumbered
// - tx bit10 set when link disconnected
// - rx bits 6,7,8 alignment, short, long
// - rx bits 9,10,11 fcs, abort, overrun
// - rx bits 12,13 protocol, sequence; 14-15 reserved
`default_nettype none
module sbd_dma
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic tx_start,
	output sbd_pkg::sbd_tx_req_t tx_req,
	input wire logic tx_done,
	input wire sbd_pkg::sbd_tx_res_t tx_res,
	input wire logic rx_pending,
	output logic rx_grant,
	output sbd_pkg::sbd_rx_buf_t rx_buf,
	input wire logic rx_done,
	input wire sbd_pkg::sbd_rx_res_t rx_res,
	output logic desc_irq
);
	typedef enum logic [3:0] {S_IDLE, S_FETCH, S_LOAD, S_CHECK, S_TX_WAIT, S_RX_WAIT, S_WB_LEN, S_WB_STAT,
		S_NEXT} sbd_state_t;

	sbd_state_t state_r;
	logic [1:0] ctrl_r;
	logic [31:0] txbase_r, rxbase_r;
	logic [11:0] rxlen_r;
	logic [sbd_pkg::IDX_W-1:0] tx_idx_r, rx_idx_r;
	logic is_rx_r, tx_hold_r, rx_hold_r;
	logic [15:0] st_r;
	logic [11:0] len_r;
	logic [15:0] ptr_hi_r;
	logic [31:0] ptr_r;
	logic [1:0] k_r;
	logic [15:0] poll_cnt_r;
	logic poll_tick_r;
	logic [15:0] dm_rdata;
	logic [1:0] dm_raddr;
	logic dm_we;
	logic own, cont;
	logic [15:0] tx_st_nxt, rx_st_nxt;

	// entry address: base + 8*index + 2*halfword
	function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [7:0] idx,
		input logic [1:0] hw);
		desc_addr = base + {21'h0, idx, 3'h0} + {29'h0, hw, 1'b0};
	endfunction

	assign own = st_r[sbd_pkg::B_OWN];
	assign cont = st_r[sbd_pkg::B_CONT];
	assign dm_we = (state_r == S_FETCH) && mem_ack;
	assign dm_raddr = (k_r == 2'h0) ? sbd_pkg::HW_PTR_HI : sbd_pkg::HW_PTR_LO;

	// status halfwords to write back: fresh result bits over the kept control bits;
	// ownership goes back unless the entry is continuous
	assign tx_st_nxt = ((st_r & ~sbd_pkg::TX_RES_MASK) | {5'h0, tx_res.disconnected, 1'b0,
		tx_res.tx_fifo_starve_flag, tx_res.abort, 7'h0}) & {15'h7FFF, cont};
	assign rx_st_nxt = ((st_r & ~sbd_pkg::RX_RES_MASK) | {2'h0, rx_res.sequence_error_flag,
		rx_res.protocol_error_flag, rx_res.rx_fifo_overflow_flag, rx_res.abort,
		rx_res.check_sequence_error_flag,
		rx_res.long_frame_flag, rx_res.short_frame_flag, rx_res.misaligned_frame_flag,
		1'b0, rx_res.first, rx_res.last, 3'h0}) & {15'h7FFF, cont};

	sbd_dmem u_dmem
	(
		.pclk(pclk),
		.we(dm_we),
		.waddr(k_r),
		.wdata(mem_rdata),
		.raddr(dm_raddr),
		.rdata(dm_rdata)
	);

	// ======================================================================
	// apb slave: zero-wait answer, decode registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (psel && !penable)
			begin
				pslverr <= 1'b0;
				case (paddr)
					sbd_pkg::A_CTRL: prdata <= {30'h0, ctrl_r};
					sbd_pkg::A_TXBASE: prdata <= txbase_r;
					sbd_pkg::A_RXBASE: prdata <= rxbase_r;
					sbd_pkg::A_RXLEN: prdata <= {20'h0, rxlen_r};
					sbd_pkg::A_STAT: prdata <= {12'h0, rx_hold_r, tx_hold_r, state_r != S_IDLE, is_rx_r,
						rx_idx_r, tx_idx_r};
					default:
					begin
						prdata <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// register writes take effect on the access cycle; base kept aligned to the 8-byte entry
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= sbd_pkg::CTRL_RESET;
			txbase_r <= 32'h0;
			rxbase_r <= 32'h0;
			rxlen_r <= sbd_pkg::RXLEN_RESET;
		end
		else if (psel && penable && pwrite)
		begin
			case (paddr)
				sbd_pkg::A_CTRL: ctrl_r <= pwdata[1:0];
				sbd_pkg::A_TXBASE: txbase_r <= {pwdata[31:3], 3'h0};
				sbd_pkg::A_RXBASE: rxbase_r <= {pwdata[31:3], 3'h0};
				sbd_pkg::A_RXLEN: rxlen_r <= pwdata[11:0];
				default: ;
			endcase
		end
	end

	// ======================================================================
	// poll divider: a ring that found no owned descriptor retries only on this tick,
	// so an idle ring does not hammer external memory
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			poll_cnt_r <= 16'h0;
			poll_tick_r <= 1'b0;
		end
		else
		begin
			poll_tick_r <= (poll_cnt_r == sbd_pkg::POLL_DIV - 16'h1);
			poll_cnt_r <= (poll_cnt_r == sbd_pkg::POLL_DIV - 16'h1) ? 16'h0 : poll_cnt_r + 16'h1;
		end
	end

	// ======================================================================
	// main sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= S_IDLE;
			is_rx_r <= 1'b0;
			k_r <= 2'h0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0;
			mem_wdata <= 16'h0;
			st_r <= 16'h0;
			len_r <= 12'h0;
			ptr_hi_r <= 16'h0;
			ptr_r <= 32'h0;
			tx_start <= 1'b0;
			tx_req <= '0;
			rx_grant <= 1'b0;
			rx_buf <= '0;
			desc_irq <= 1'b0;
			tx_idx_r <= '0;
			rx_idx_r <= '0;
			tx_hold_r <= 1'b0;
			rx_hold_r <= 1'b0;
		end
		else
		begin
			tx_start <= 1'b0;
			rx_grant <= 1'b0;
			desc_irq <= 1'b0;
			if (poll_tick_r)
			begin
				tx_hold_r <= 1'b0;
				rx_hold_r <= 1'b0;
			end
			case (state_r)
				S_IDLE:
				begin
					k_r <= 2'h0;
					// rx first: a waiting frame overruns the receiver, a waiting tx buffer does not
					if (ctrl_r[1] && rx_pending && !rx_hold_r)
					begin
						is_rx_r <= 1'b1;
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= desc_addr(rxbase_r, rx_idx_r, sbd_pkg::HW_STAT);
						state_r <= S_FETCH;
					end
					else if (ctrl_r[0] && !tx_hold_r)
					begin
						is_rx_r <= 1'b0;
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= desc_addr(txbase_r, tx_idx_r, sbd_pkg::HW_STAT);
						state_r <= S_FETCH;
					end
				end
				S_FETCH:
				begin
					if (mem_ack)
					begin
						if (k_r == sbd_pkg::HW_STAT)
							st_r <= mem_rdata;
						if (k_r == sbd_pkg::HW_LEN)
							len_r <= mem_rdata[15:sbd_pkg::LEN_LSB];
						k_r <= k_r + 2'h1;
						mem_addr <= mem_addr + 32'h2;
						if (k_r == sbd_pkg::HW_PTR_LO)
						begin
							mem_req <= 1'b0;
							k_r <= 2'h0;
							state_r <= S_LOAD;
						end
					end
				end
				S_LOAD:
				begin
					// two-stage read of the pointer halves out of the descriptor store
					k_r <= k_r + 2'h1;
					if (k_r == 2'h1)
						ptr_hi_r <= dm_rdata;
					if (k_r == 2'h2)
					begin
						ptr_r <= {ptr_hi_r, dm_rdata};
						state_r <= S_CHECK;
					end
				end
				S_CHECK:
				begin
					if (!own && !cont)
					begin
						if (is_rx_r)
							rx_hold_r <= 1'b1;
						else
							tx_hold_r <= 1'b1;
						state_r <= S_IDLE;
					end
					else if (is_rx_r)
					begin
						rx_grant <= 1'b1;
						rx_buf <= '{addr: ptr_r, cap: rxlen_r};
						state_r <= S_RX_WAIT;
					end
					else
					begin
						tx_start <= 1'b1;
						tx_req <= '{addr: ptr_r, len: len_r, last: st_r[sbd_pkg::B_LAST],
							unnumbered: st_r[sbd_pkg::B_UNNUM],
							repeat_packet_flag: st_r[sbd_pkg::B_REPEAT]};
						state_r <= S_TX_WAIT;
					end
				end
				S_TX_WAIT:
				begin
					if (tx_done)
					begin
						// write data set with the request: a zero-wait memory takes it at once
						st_r <= tx_st_nxt;
						mem_wdata <= tx_st_nxt;
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= desc_addr(txbase_r, tx_idx_r, sbd_pkg::HW_STAT);
						state_r <= S_WB_STAT;
					end
				end
				S_RX_WAIT:
				begin
					if (rx_done)
					begin
						st_r <= rx_st_nxt;
						len_r <= rx_res.count;
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= desc_addr(rxbase_r, rx_idx_r, sbd_pkg::HW_LEN);
						mem_wdata <= {rx_res.count, 4'h0};
						state_r <= S_WB_LEN;
					end
				end
				S_WB_LEN:
				begin
					// count goes out before status so software never sees ownership back with a stale count
					if (mem_ack)
					begin
						mem_addr <= desc_addr(rxbase_r, rx_idx_r, sbd_pkg::HW_STAT);
						mem_wdata <= st_r;
						state_r <= S_WB_STAT;
					end
				end
				S_WB_STAT:
				begin
					if (mem_ack)
					begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						desc_irq <= st_r[sbd_pkg::B_INT];
						state_r <= S_NEXT;
					end
				end
				S_NEXT:
				begin
					// continuous entries are revisited; an 8-bit index wraps past entry 255 anyway
					if (!cont)
					begin
						if (is_rx_r)
							rx_idx_r <= st_r[sbd_pkg::B_WRAP] ? '0 : rx_idx_r + 8'h1;
						else
							tx_idx_r <= st_r[sbd_pkg::B_WRAP] ? '0 : tx_idx_r + 8'h1;
					end
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ======================================================================
	// checks
	AST_MEM_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request changed before acknowledge");
	AST_TX_OWNED: assert property (@(posedge pclk) disable iff (!presetn)
		tx_start |-> $past(st_r[0]) || $past(st_r[2]))
		else $error("tx buffer started without ownership");
	AST_RX_OWNED: assert property (@(posedge pclk) disable iff (!presetn)
		rx_grant |-> $past(st_r[0]) || $past(st_r[2]))
		else $error("rx buffer granted without ownership");
	AST_PTR: assert property (@(posedge pclk) disable iff (!presetn)
		tx_start |-> tx_req.addr == ptr_r)
		else $error("tx address does not match descriptor pointer");
	AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == S_NEXT && !is_rx_r && st_r[1] && !st_r[2] |=> tx_idx_r == 8'h0)
		else $error("wrap bit did not return tx index to zero");
	AST_CONT: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == S_NEXT && st_r[2] |=> $stable(tx_idx_r) && $stable(rx_idx_r))
		else $error("continuous descriptor advanced");
	AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == S_WB_STAT && mem_ack && !st_r[2] |-> mem_wdata[0] == 1'b0 && mem_we)
		else $error("ownership not returned on writeback");
	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == S_WB_STAT && mem_ack |=> desc_irq == $past(st_r[5]))
		else $error("interrupt pulse does not follow descriptor bit");
	AST_STARVE: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == S_TX_WAIT && tx_done |=> st_r[8] == $past(tx_res.tx_fifo_starve_flag))
		else $error("underrun flag not reported");
	AST_RX_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == S_RX_WAIT && rx_done |=> st_r[4] == $past(rx_res.first) && mem_wdata[15:4] == len_r)
		else $error("first flag or count not reported");
endmodule
`default_nettype wire

//--- verilog/sbd_dmem.sv
// small descriptor store: four halfwords, registered read port
`default_nettype none
module sbd_dmem
(
	input wire logic pclk,
	input wire logic we,
	input wire logic [1:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [1:0] raddr,
	output logic [15:0] rdata
);
	logic [15:0] mem [0:3];

	// ======================================================================
	// storage; no reset needed, every word is written before it is read
	always_ff @(posedge pclk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

//--- verilog/sbd_pkg.sv
// package: register map, descriptor field layout and carrier types of the descriptor engine
`default_nettype none
package sbd_pkg;
	// ======================================================================
	// register map (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TXBASE = 8'h04;
	localparam logic [7:0] A_RXBASE = 8'h08;
	localparam logic [7:0] A_RXLEN = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [11:0] RXLEN_RESET = 12'h200;
	// ======================================================================
	// descriptor layout: halfword index within the 8-byte entry
	localparam logic [1:0] HW_STAT = 2'h0;
	localparam logic [1:0] HW_LEN = 2'h1;
	localparam logic [1:0] HW_PTR_HI = 2'h2;
	localparam logic [1:0] HW_PTR_LO = 2'h3;
	localparam int LEN_LSB = 4;
	localparam int IDX_W = 8;
	// status/control bits shared by both rings, except B_FIRST which only the receive ring uses
	localparam int B_OWN = 0;
	localparam int B_WRAP = 1;
	localparam int B_CONT = 2;
	localparam int B_LAST = 3;
	localparam int B_FIRST = 4;
	localparam int B_INT = 5;
	// transmit-only bits
	localparam int B_REPEAT = 6;
	localparam int B_TX_ABORT = 7;
	localparam int B_STARVE = 8;
	localparam int B_UNNUM = 9;
	localparam int B_DISC = 10;
	// receive-only bits
	localparam int B_MISALIGN = 6;
	localparam int B_SHORT = 7;
	localparam int B_LONG = 8;
	localparam int B_CRC = 9;
	localparam int B_RX_ABORT = 10;
	localparam int B_OVF = 11;
	localparam int B_PROTO = 12;
	localparam int B_SEQ = 13;
	// bits the engine rewrites on completion
	localparam logic [15:0] TX_RES_MASK = 16'h0580;
	localparam logic [15:0] RX_RES_MASK = 16'h3FD8;
	// retry interval for a ring whose descriptor was not owned
	localparam logic [15:0] POLL_DIV = 16'h03E8;
	// ======================================================================
	// carriers
	typedef struct packed {
		logic [31:0] addr;
		logic [11:0] len;
		logic last;
		logic unnumbered;
		logic repeat_packet_flag;
	} sbd_tx_req_t;
	typedef struct packed {
		logic abort;
		logic tx_fifo_starve_flag;
		logic disconnected;
	} sbd_tx_res_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [11:0] cap;
	} sbd_rx_buf_t;
	typedef struct packed {
		logic [11:0] count;
		logic first;
		logic last;
		logic misaligned_frame_flag;
		logic short_frame_flag;
		logic long_frame_flag;
		logic check_sequence_error_flag;
		logic abort;
		logic rx_fifo_overflow_flag;
		logic protocol_error_flag;
		logic sequence_error_flag;
	} sbd_rx_res_t;
endpackage
`default_nettype wire
